// [shared/cwd_regs.vh]
`ifndef CWD_REGS_VH
`define CWD_REGS_VH
// Field positions of the configuration word
`define CWD_WORD_W        14
`define CWD_LV_PROG_BIT   13
`define CWD_DBG_BIT       12
`define CWD_RSV_HI_BIT    11
`define CWD_BOR_BIT       10
`define CWD_STK_BIT       9
`define CWD_MUL_BIT       8
`define CWD_RSV_MID_HI    7
`define CWD_RSV_MID_LO    6
`define CWD_CAP_HI        5
`define CWD_CAP_LO        4
`define CWD_RSV_LO_HI     3
`define CWD_RSV_LO_LO     2
`define CWD_WRP_HI        1
`define CWD_WRP_LO        0
// Mask of positions that read as one regardless of storage
`define CWD_RSV_MASK      14'h08cc
// Erased word value
`define CWD_BLANK         14'h3fff
// Register offsets on the plain port
`define CWD_ADDR_WORD     4'h0
`define CWD_ADDR_STAT     4'h1
`define CWD_ADDR_PROG     4'h2
// Status register bit positions
`define CWD_ST_PROG_MODE  0
`define CWD_ST_LV_ENTRY   1
`define CWD_ST_REFUSED    2
// Protection boundaries, word addresses
`define CWD_BOUND_200     15'h0200
`define CWD_BOUND_800     15'h0800
`define CWD_BOUND_1000    15'h1000
`endif

// [verilog/cwd_protect.v]
`timescale 1ns/10ps
// ---------------------------------------------
// Self-write protection range decode
// ---------------------------------------------
`include "cwd_regs.vh"
module cwd_protect (
   input  wire [1:0]  protect_sel,
   input  wire        large_mem,
   input  wire [14:0] wr_addr,
   output reg         wr_allowed
);
   // Lowest writable address for the chosen setting
   reg [14:0] bound;
   reg        none_ok;
   always @* begin
      bound   = 15'h0000;
      none_ok = 1'b0;
      if (large_mem) begin
         case (protect_sel)
            2'b11: bound = 15'h0000;
            2'b10: bound = `CWD_BOUND_200;
            2'b01: bound = `CWD_BOUND_1000;
            default: none_ok = 1'b1;
         endcase
      end else begin
         case (protect_sel)
            2'b11: bound = 15'h0000;
            2'b10: bound = `CWD_BOUND_200;
            2'b01: bound = `CWD_BOUND_800;
            default: none_ok = 1'b1;
         endcase
      end
      wr_allowed = !none_ok && (wr_addr >= bound);
   end
endmodule // cwd_protect

// [verilog/cwd_decode.v]
`timescale 1ns/10ps
`include "cwd_regs.vh"
module cwd_decode #(
   parameter LV_ONLY   = 1'b0,
   parameter LARGE_MEM = 1'b1
) (
   input  wire        clk_sys,
   input  wire        rst_n,
   input  wire [13:0] nvm_word,
   input  wire        nvm_blank,
   input  wire        prog_entry_lv_raw,
   input  wire        prog_entry_hv_raw,
   input  wire        prog_exit_raw,
   input  wire        stack_fault,
   input  wire [14:0] self_wr_addr,
   input  wire        self_wr_req,
   input  wire        self_rd_req,
   input  wire [3:0]  reg_addr,
   input  wire [13:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [13:0] reg_rdata,
   output reg         low_voltage_prog_enable,
   output reg         debugger_enable,
   output reg         serial_prog_pins_gpio,
   output reg         brownout_level_select,
   output reg         stack_fault_reset_enable,
   output reg         clock_multiplier_enable,
   output reg         regulator_cap_on_pin_zero,
   output reg         regulator_cap_on_pin_five,
   output reg         regulator_cap_on_pin_six,
   output reg  [1:0]  self_write_protect,
   output wire        stack_fault_reset,
   output wire        self_wr_grant,
   output wire        self_rd_grant,
   output wire        lv_entry_allowed
);
   // ---------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------
   reg [2:0] sync_a;
   reg [2:0] sync_b;
   wire      entry_lv = sync_b[0];
   wire      entry_hv = sync_b[1];
   wire      exit_req = sync_b[2];
   // Two flops on each programming pin event
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
      end else begin
         sync_a <= {prog_exit_raw, prog_entry_hv_raw, prog_entry_lv_raw};
         sync_b <= sync_a;
      end
   end

   // ---------------------------------------------
   // Stored word and programming state
   // ---------------------------------------------
   reg [13:0] word;
   reg        loaded;
   reg        prog_mode;
   reg        lv_entry;
   reg        refused;
   reg [13:0] next_word;
   reg        next_refused;

   // Word as read back, with fixed-one positions forced
   wire [13:0] raw_view = nvm_blank ? `CWD_BLANK : nvm_word;
   wire [13:0] seen;
   assign seen = (loaded ? word : raw_view) | `CWD_RSV_MASK;

   // Programming write of the stored word
   always @* begin
      next_word    = word;
      next_refused = 1'b0;
      if (reg_wr && reg_addr == `CWD_ADDR_PROG && prog_mode) begin
         next_word = reg_wdata | `CWD_RSV_MASK;
         if (lv_entry && !reg_wdata[`CWD_LV_PROG_BIT]) begin
            next_word[`CWD_LV_PROG_BIT] = 1'b1;
            next_refused            = 1'b1;
         end
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         word      <= `CWD_BLANK;
         loaded    <= 1'b0;
         prog_mode <= 1'b0;
         lv_entry  <= 1'b0;
         refused   <= 1'b0;
      end else begin
         if (!loaded) begin
            word   <= raw_view | `CWD_RSV_MASK;
            loaded <= 1'b1;
         end else begin
            word <= next_word;
         end
         if (next_refused)
            refused <= 1'b1;
         else if (reg_wr && reg_addr == `CWD_ADDR_STAT &&
                  reg_wdata[`CWD_ST_REFUSED])
            refused <= 1'b0;
         if (exit_req) begin
            prog_mode <= 1'b0;
            lv_entry  <= 1'b0;
         end else if (!prog_mode && entry_hv) begin
            prog_mode <= 1'b1;
            lv_entry  <= 1'b0;
         end else if (!prog_mode && entry_lv && lv_entry_allowed) begin
            prog_mode <= 1'b1;
            lv_entry  <= 1'b1;
         end
      end
   end

   assign lv_entry_allowed = low_voltage_prog_enable;

   // ---------------------------------------------
   // Decoded control outputs, held from load
   // ---------------------------------------------
   reg dec_done;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dec_done                  <= 1'b0;
         low_voltage_prog_enable   <= 1'b1;
         debugger_enable           <= 1'b0;
         serial_prog_pins_gpio     <= 1'b1;
         brownout_level_select     <= 1'b1;
         stack_fault_reset_enable  <= 1'b1;
         clock_multiplier_enable   <= 1'b1;
         regulator_cap_on_pin_zero <= 1'b0;
         regulator_cap_on_pin_five <= 1'b0;
         regulator_cap_on_pin_six  <= 1'b0;
         self_write_protect        <= 2'h3;
      end else if (loaded && !dec_done) begin
         dec_done                <= 1'b1;
         low_voltage_prog_enable <= word[`CWD_LV_PROG_BIT];
         debugger_enable         <= !word[`CWD_DBG_BIT];
         serial_prog_pins_gpio   <= word[`CWD_DBG_BIT];
         brownout_level_select   <= word[`CWD_BOR_BIT];
         stack_fault_reset_enable <= word[`CWD_STK_BIT];
         clock_multiplier_enable <= word[`CWD_MUL_BIT];
         regulator_cap_on_pin_zero <= !LV_ONLY &&
            word[`CWD_CAP_HI:`CWD_CAP_LO] == 2'b00;
         regulator_cap_on_pin_five <= !LV_ONLY &&
            word[`CWD_CAP_HI:`CWD_CAP_LO] == 2'b01;
         regulator_cap_on_pin_six  <= !LV_ONLY &&
            word[`CWD_CAP_HI:`CWD_CAP_LO] == 2'b10;
         self_write_protect <= word[`CWD_WRP_HI:`CWD_WRP_LO];
      end
   end

   assign stack_fault_reset = stack_fault && stack_fault_reset_enable;

   // ---------------------------------------------
   // Self-write protection
   // ---------------------------------------------
   wire wr_ok;
   cwd_protect u_protect (
      .protect_sel (self_write_protect),
      .large_mem   (LARGE_MEM),
      .wr_addr     (self_wr_addr),
      .wr_allowed  (wr_ok)
   );
   assign self_wr_grant = self_wr_req && wr_ok;
   assign self_rd_grant = self_rd_req;

   // ---------------------------------------------
   // Register read port
   // ---------------------------------------------
   reg [13:0] rd_view;
   always @* begin
      rd_view = 14'h0000;
      case (reg_addr)
         `CWD_ADDR_WORD: begin
            rd_view = seen;
            if (LV_ONLY)
               rd_view[`CWD_CAP_HI:`CWD_CAP_LO] = 2'b11;
         end
         `CWD_ADDR_STAT: begin
            rd_view[`CWD_ST_PROG_MODE] = prog_mode;
            rd_view[`CWD_ST_LV_ENTRY]  = lv_entry;
            rd_view[`CWD_ST_REFUSED]   = refused;
         end
         default: rd_view = 14'h0000;
      endcase
   end

   // Read data one cycle after the strobe
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         reg_rdata <= 14'h0000;
      else if (reg_rd)
         reg_rdata <= rd_view;
      else
         reg_rdata <= 14'h0000;
   end
endmodule // cwd_decode

// [tb/cwd_decode_monitor.sv]
`timescale 1ns/10ps
// ------------------------------
// Decoder port checks
// ------------------------------
module cwd_decode_monitor (
   input wire        clk_sys,
   input wire        rst_n,
   input wire        stack_fault,
   input wire [14:0] self_wr_addr,
   input wire        self_wr_req,
   input wire        self_rd_req,
   input wire [3:0]  reg_addr,
   input wire        reg_rd,
   input wire [13:0] reg_rdata,
   input wire        debugger_enable,
   input wire        serial_prog_pins_gpio,
   input wire        brownout_level_select,
   input wire        stack_fault_reset_enable,
   input wire        clock_multiplier_enable,
   input wire        regulator_cap_on_pin_zero,
   input wire        regulator_cap_on_pin_five,
   input wire        regulator_cap_on_pin_six,
   input wire [1:0]  self_write_protect,
   input wire        stack_fault_reset,
   input wire        self_wr_grant,
   input wire        self_rd_grant
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_stk;
      stack_fault |-> stack_fault_reset == stack_fault_reset_enable;
   endproperty
   a_stk: assert property (p_stk) else $error("stack reset wrong");
   property p_rd;
      self_rd_req |-> self_rd_grant;
   endproperty
   a_rd: assert property (p_rd) else $error("read refused");
   property p_dbg;
      debugger_enable != serial_prog_pins_gpio;
   endproperty
   a_dbg: assert property (p_dbg) else $error("debug pins clash");
   property p_cap;
      $onehot0({regulator_cap_on_pin_zero, regulator_cap_on_pin_five,
                regulator_cap_on_pin_six});
   endproperty
   a_cap: assert property (p_cap) else $error("cap on two pins");
   property p_hold;
      $past(rst_n, 3) |-> $stable({brownout_level_select, debugger_enable,
         stack_fault_reset_enable, clock_multiplier_enable,
         self_write_protect});
   endproperty
   a_hold: assert property (p_hold) else $error("decode moved");
   property p_rsv;
      reg_rd && reg_addr == 4'h0 |=> (reg_rdata & 14'h08cc) == 14'h08cc;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved not one");
   property p_open;
      self_wr_req && self_write_protect == 2'b11 |-> self_wr_grant;
   endproperty
   a_open: assert property (p_open) else $error("write blocked");
   property p_lock;
      self_wr_req && self_write_protect == 2'b01 && self_wr_addr < 15'h1000
         |-> !self_wr_grant;
   endproperty
   a_lock: assert property (p_lock) else $error("write let in");
endmodule // cwd_decode_monitor

bind cwd_decode cwd_decode_monitor u_mon (.clk_sys, .rst_n, .stack_fault,
   .self_wr_addr, .self_wr_req, .self_rd_req, .reg_addr, .reg_rd,
   .reg_rdata, .debugger_enable, .serial_prog_pins_gpio,
   .brownout_level_select, .stack_fault_reset_enable,
   .clock_multiplier_enable, .regulator_cap_on_pin_zero,
   .regulator_cap_on_pin_five, .regulator_cap_on_pin_six,
   .self_write_protect, .stack_fault_reset, .self_wr_grant,
   .self_rd_grant);

// [tb/testbench.sv]
`timescale 1ns/10ps
// ------------------------------
// Decoder testbench
// ------------------------------
module testbench;
   logic        clk_sys, rst_n, nvm_blank, stack_fault, self_wr_req;
   logic        prog_entry_lv_raw, prog_entry_hv_raw, prog_exit_raw;
   logic        self_rd_req, reg_wr, reg_rd;
   logic [13:0] nvm_word, reg_wdata, reg_rdata, rd_val;
   logic [14:0] self_wr_addr;
   logic [3:0]  reg_addr;
   logic [1:0]  self_write_protect;
   logic        low_voltage_prog_enable, debugger_enable, serial_prog_pins_gpio;
   logic        brownout_level_select, stack_fault_reset_enable;
   logic        clock_multiplier_enable, regulator_cap_on_pin_zero;
   logic        regulator_cap_on_pin_five, regulator_cap_on_pin_six;
   logic        stack_fault_reset, self_wr_grant, self_rd_grant;
   logic        lv_entry_allowed;
   int          n_errors, checks;
   wire  [2:0]  caps = {regulator_cap_on_pin_zero, regulator_cap_on_pin_five,
                        regulator_cap_on_pin_six};
   wire  [10:0] dec = {low_voltage_prog_enable, debugger_enable,
      serial_prog_pins_gpio, brownout_level_select, stack_fault_reset_enable,
      clock_multiplier_enable, caps, self_write_protect};

   cwd_decode uut (.clk_sys, .rst_n, .nvm_word, .nvm_blank,
      .prog_entry_lv_raw, .prog_entry_hv_raw, .prog_exit_raw, .stack_fault,
      .self_wr_addr, .self_wr_req, .self_rd_req, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .low_voltage_prog_enable,
      .debugger_enable, .serial_prog_pins_gpio, .brownout_level_select,
      .stack_fault_reset_enable, .clock_multiplier_enable,
      .regulator_cap_on_pin_zero, .regulator_cap_on_pin_five,
      .regulator_cap_on_pin_six, .self_write_protect, .stack_fault_reset,
      .self_wr_grant, .self_rd_grant, .lv_entry_allowed);

   // Clock of 10 ns
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task chk(input string nm, input logic [14:0] got, exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s: expected %h, seen %h", nm, exp, got);
      end
   endtask

   // Reload the word through a reset
   task load(input logic [13:0] w, input logic b);
      @(posedge clk_sys);
      rst_n     <= 1'b0;
      nvm_word  <= w;
      nvm_blank <= b;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask

   task wr(input logic [3:0] a, input logic [13:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task rd(input logic [3:0] a);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask

   task grant(input logic [14:0] a, input logic e);
      @(posedge clk_sys);
      self_wr_addr <= a;
      self_wr_req  <= 1'b1;
      #1 chk("grant", self_wr_grant, e);
   endtask

   task fault(input logic e);
      @(posedge clk_sys);
      stack_fault <= 1'b1;
      #1 chk("stack reset", stack_fault_reset, e);
      @(posedge clk_sys);
      stack_fault <= 1'b0;
   endtask

   task t_words;
      load(14'h0000, 1'b1);
      chk("blank decode", dec, 11'h5e3);
      rd(4'h0);
      chk("blank word", rd_val, 14'h3fff);
      fault(1'b1);
      rd(4'h7);
      chk("unmapped", rd_val, 14'h0000);
      load(14'h0000, 1'b0);
      chk("zero decode", dec, 11'h210);
      chk("lv allowed", lv_entry_allowed, 1'b0);
      rd(4'h0);
      chk("zero word", rd_val, 14'h08cc);
      fault(1'b0);
      nvm_word <= 14'h3fff;
      repeat (4) @(posedge clk_sys);
      chk("held decode", dec, 11'h210);
   endtask

   task t_caps;
      for (int c = 0; c < 4; c++) begin
         load(14'h3fcf | 14'(c << 4), 1'b0);
         chk("cap pins", caps, 3'b100 >> c);
      end
   endtask

   task t_protect;
      load(14'h3fff, 1'b0);
      grant(15'h0000, 1'b1);
      load(14'h3ffe, 1'b0);
      grant(15'h01ff, 1'b0);
      grant(15'h0200, 1'b1);
      load(14'h3ffd, 1'b0);
      grant(15'h0fff, 1'b0);
      grant(15'h1000, 1'b1);
      chk("read grant", self_rd_grant, 1'b1);
   endtask

   task t_prog;
      load(14'h3fff, 1'b0);
      chk("lv allowed", lv_entry_allowed, 1'b1);
      prog_entry_lv_raw <= 1'b1;
      repeat (4) @(posedge clk_sys);
      wr(4'h2, 14'h1fff);
      rd(4'h0);
      chk("lv word", rd_val, 14'h3fff);
      rd(4'h1);
      chk("refused", rd_val[2], 1'b1);
      prog_entry_lv_raw <= 1'b0;
      prog_exit_raw     <= 1'b1;
      repeat (4) @(posedge clk_sys);
      prog_exit_raw     <= 1'b0;
      prog_entry_hv_raw <= 1'b1;
      repeat (4) @(posedge clk_sys);
      wr(4'h2, 14'h1fff);
      rd(4'h0);
      chk("hv word", rd_val, 14'h1fff);
      chk("prog decode", dec, 11'h5e3);
   endtask

   task give_verdict;
      if (n_errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Hang guard
   initial begin
      #100000;
      n_errors++;
      give_verdict;
   end

   // Main sequence
   initial begin
      {rst_n, nvm_blank, stack_fault, self_wr_req, reg_wr, reg_rd} = '0;
      {prog_entry_lv_raw, prog_entry_hv_raw, prog_exit_raw} = '0;
      {nvm_word, reg_wdata, self_wr_addr, reg_addr} = '0;
      self_rd_req = 1'b1;
      t_words;
      t_caps;
      t_protect;
      t_prog;
      give_verdict;
   end
endmodule // testbench
